// ===== inc/mac_wake_pkg.sv
// Purpose: shared constants for the vlan tag and wake-up detect block
// Assumes: 32-bit ahb-lite register bus, byte-wide receive stream
// Notes:   register indices are word numbers; byte address = index * 4
`default_nettype none

package mac_wake_pkg;

    // ********************************************************
    // bus
    // ********************************************************
    localparam int HADDR_W = 32;
    localparam int HDATA_W = 32;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // ********************************************************
    // register indices
    // ********************************************************
    localparam logic [5:0] IDX_VLAN_ONE = 6'h09;
    localparam logic [5:0] IDX_VLAN_TWO = 6'h0A;
    localparam logic [5:0] IDX_WAKE_FILTER = 6'h0B;
    localparam logic [5:0] IDX_WAKE_CTRL = 6'h0C;
    localparam logic [5:0] IDX_FRAME_STAT = 6'h0D;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h0E;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h0F;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h10;

    // ********************************************************
    // fields and reset values
    // ********************************************************
    localparam int WCS_GUE = 9;
    localparam int WCS_WFR = 6;
    localparam int WCS_MPR = 5;
    localparam int WCS_WFE = 2;
    localparam int WCS_MPE = 1;
    localparam int FST_VLAN_TAG_ONE = 0;
    localparam int FST_VLAN_TAG_TWO = 1;
    localparam int FST_LONG = 2;
    localparam int FST_LEN = 16;
    localparam int IRQ_MAGIC = 0;
    localparam int IRQ_WFRAME = 1;
    localparam int IRQ_UNICAST = 2;
    localparam int IRQ_OVERSIZE = 3;
    localparam int IRQ_W = 4;
    localparam logic [31:0] REG_RST = 32'h0000_0000;

    // ********************************************************
    // frame layout and wake filter
    // ********************************************************
    localparam int LEN_W = 11;
    localparam logic [10:0] LEN_SAT = 11'h7FF;
    localparam logic [10:0] LEN_MAX_PLAIN = 11'd1518;
    localparam logic [10:0] LEN_MAX_VLAN = 11'd1522;
    localparam logic [10:0] TYPE_POS_HI = 11'd12;
    localparam logic [10:0] TYPE_POS_LO = 11'd13;
    localparam int FILT_WORDS = 8;
    localparam int FILT_NUM = 4;
    localparam int FILT_SPAN = 32;
    localparam int WORD_CMD = 4;
    localparam int WORD_OFF = 5;
    localparam int WORD_CRC = 6;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [7:0] MAGIC_SYNC_BYTE = 8'hFF;
    localparam logic [2:0] MAGIC_SYNC_LEN = 3'h6;
    localparam logic [3:0] MAGIC_LAST_REP = 4'hF;
    localparam logic [2:0] MAGIC_LAST_BYTE = 3'h5;

endpackage : mac_wake_pkg

`default_nettype wire

// ===== src/mac_vlan_wake.sv
// Purpose: vlan tag compare, length limit and wake-up detection
// Assumes: ahb-lite single slave, byte stream synchronous to ref_clk
// Notes:   reads take one wait state, writes none
// Functional notes
// R1 - first tag compared with bytes 13, 14
// R2 - second tag compared with bytes 13, 14
// R3 - tagged frames allowed 1522 bytes, else 1518
// R4 - software programs tags to 0x8100; the bench programs the second tag to 0x88A8
// R5 - reset points filter index at word 0
// R6 - each filter write advances to next word
// R7 - index wraps after the eighth word
// R8 - filter port is write only, reads zero
// R9 - unicast wake when enabled and bit0 zero
// R10 - valid wake frame sets its status flag
// R11 - valid magic packet sets its status flag
// R12 - wake frame enable arms filter matching
// R13 - magic enable gates magic packet wake
// R14 - magic: six 0xFF then sixteen addresses
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module mac_vlan_wake (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [mac_wake_pkg::HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [mac_wake_pkg::HDATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [mac_wake_pkg::HDATA_W-1:0] hrdata,
    output logic [1:0] hresp,
    input wire logic rx_valid,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_err,
    input wire logic [7:0] rx_data,
    input wire logic [47:0] station_addr,
    input wire logic power_save,
    output logic wake_req,
    output logic frame_done,
    output logic vlan_one_hit,
    output logic vlan_two_hit,
    output logic frame_too_long,
    output logic irq
);
    import mac_wake_pkg::*;

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic [15:0] vlan_one;
        logic [15:0] vlan_two;
        logic global_unicast_wake_enable;
        logic wfe;
        logic mpe;
        logic wfr;
        logic magic_packet_received;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic [2:0] wf_idx;
        logic ph_act;
        logic ph_wr;
        logic [5:0] ph_idx;
        logic rd_wait;
        logic [31:0] hrdata;
        logic [LEN_W-1:0] rx_len;
        logic [7:0] type_hi;
        logic [7:0] type_lo;
        logic unicast;
        logic [FILT_NUM-1:0][15:0] crc;
        logic frame_done;
        logic v1;
        logic v2;
        logic long;
        logic [LEN_W-1:0] last_len;
        logic wake_req;
    } mw_st_t;

    mw_st_t q;
    mw_st_t n;

    logic [FILT_WORDS*32-1:0] fwords;
    logic take;
    logic bus_wr;
    logic fw_wr;
    logic magic_found;
    logic [31:0] rdv;
    logic [LEN_W-1:0] pos;
    logic [LEN_W-1:0] off;
    logic [LEN_W-1:0] rel;
    logic [LEN_W-1:0] limit;
    logic [15:0] tag;
    logic [15:0] c;
    logic wf_hit;
    logic good;
    logic ev_magic;
    logic ev_wf;
    logic ev_uc;

    // msb-first crc-16 over one byte
    function automatic logic [15:0] crc16_byte(input logic [15:0] ci,
                                               input logic [7:0] d);
        logic [15:0] r;
        r = ci;
        for (int b = 7; b >= 0; b--) begin
            if (r[15] ^ d[b]) begin
                r = {r[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc16_byte

    // ********************************************************
    // submodules
    // ********************************************************
    wake_filter_mem #(
        .WIDTH(32),
        .DEPTH(FILT_WORDS),
        .AW(3)
    ) u_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(fw_wr),
        .wr_idx(q.wf_idx),
        .wr_data(hwdata),
        .words(fwords)
    );

    magic_detect u_magic (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .byte_valid(rx_valid),
        .frame_start(rx_sof),
        .byte_data(rx_data),
        .station_addr(station_addr),
        .found(magic_found)
    );

    // ********************************************************
    // bus decode
    // ********************************************************
    assign take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
    assign bus_wr = q.ph_act & q.ph_wr & hready;
    // R6 filter writes go to the indexed word
    assign fw_wr = bus_wr & (q.ph_idx == IDX_WAKE_FILTER);

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        n = q;
        rdv = 32'h0000_0000;
        pos = 11'h000;
        off = 11'h000;
        rel = 11'h000;
        limit = LEN_MAX_PLAIN;
        tag = 16'h0000;
        c = CRC_INIT;
        wf_hit = 1'b0;
        good = 1'b0;
        ev_magic = 1'b0;
        ev_wf = 1'b0;
        ev_uc = 1'b0;
        n.frame_done = 1'b0;
        n.wake_req = 1'b0;

        // address phase; the read wait cycle stalls the bus
        if (hready) begin
            n.ph_act = take;
            n.ph_wr = hwrite;
            n.ph_idx = haddr[7:2];
            n.rd_wait = take & ~hwrite;
        end else begin
            n.rd_wait = 1'b0;
        end

        // R8 filter port and clear register read zero
        case (q.ph_idx)
            IDX_VLAN_ONE: rdv = {16'h0000, q.vlan_one};
            IDX_VLAN_TWO: rdv = {16'h0000, q.vlan_two};
            IDX_WAKE_CTRL: begin
                rdv[WCS_GUE] = q.global_unicast_wake_enable;
                rdv[WCS_WFR] = q.wfr;
                rdv[WCS_MPR] = q.magic_packet_received;
                rdv[WCS_WFE] = q.wfe;
                rdv[WCS_MPE] = q.mpe;
            end
            IDX_FRAME_STAT: begin
                rdv[FST_VLAN_TAG_ONE] = q.v1;
                rdv[FST_VLAN_TAG_TWO] = q.v2;
                rdv[FST_LONG] = q.long;
                rdv[FST_LEN +: LEN_W] = q.last_len;
            end
            IDX_IRQ_STATUS: rdv[IRQ_W-1:0] = q.irq_st;
            IDX_IRQ_ENABLE: rdv[IRQ_W-1:0] = q.irq_en;
            default: rdv = 32'h0000_0000;
        endcase
        if (q.rd_wait) begin
            n.hrdata = rdv;
        end

        // register writes; status clears come before hardware sets
        if (bus_wr) begin
            case (q.ph_idx)
                IDX_VLAN_ONE: n.vlan_one = hwdata[15:0];
                IDX_VLAN_TWO: n.vlan_two = hwdata[15:0];
                IDX_WAKE_CTRL: begin
                    n.global_unicast_wake_enable = hwdata[WCS_GUE];
                    n.wfe = hwdata[WCS_WFE];
                    n.mpe = hwdata[WCS_MPE];
                    if (hwdata[WCS_WFR]) begin
                        n.wfr = 1'b0;
                    end
                    if (hwdata[WCS_MPR]) begin
                        n.magic_packet_received = 1'b0;
                    end
                end
                IDX_IRQ_CLEAR: n.irq_st = q.irq_st & ~hwdata[IRQ_W-1:0];
                IDX_IRQ_ENABLE: n.irq_en = hwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // R7 three-bit index wraps after word seven
        if (fw_wr) begin
            n.wf_idx = q.wf_idx + 3'h1;
        end

        if (rx_valid) begin
            pos = rx_sof ? 11'h000 : q.rx_len;
            n.rx_len = (pos == LEN_SAT) ? pos : pos + 11'h001;
            if (pos == 11'h000) begin
                n.unicast = ~rx_data[0];
            end
            if (pos == TYPE_POS_HI) begin
                n.type_hi = rx_data;
            end
            if (pos == TYPE_POS_LO) begin
                n.type_lo = rx_data;
            end
            // R12 masked bytes feed each filter's crc
            for (int f = 0; f < FILT_NUM; f++) begin
                off = {3'h0, fwords[WORD_OFF*32 + 8*f +: 8]};
                rel = pos - off;
                c = rx_sof ? CRC_INIT : q.crc[f];
                if (pos >= off && rel < 11'(FILT_SPAN) &&
                    fwords[f*32 + int'(rel[4:0])]) begin
                    c = crc16_byte(c, rx_data);
                end
                n.crc[f] = c;
                if (fwords[WORD_CMD*32 + 8*f] &&
                    c == fwords[(WORD_CRC + f/2)*32 + 16*(f%2) +: 16]) begin
                    wf_hit = 1'b1;
                end
            end
            if (rx_eof) begin
                tag = {n.type_hi, n.type_lo};
                // R1 first tag compare
                n.v1 = (tag == q.vlan_one);
                // R2 second tag compare
                n.v2 = (tag == q.vlan_two);
                // R3 raised limit for tagged frames
                limit = (n.v1 | n.v2) ? LEN_MAX_VLAN : LEN_MAX_PLAIN;
                n.long = (n.rx_len > limit);
                n.last_len = n.rx_len;
                n.frame_done = 1'b1;
                good = ~rx_err;
                // R13 magic wake gated by its enable
                ev_magic = good & q.mpe & magic_found;
                // R12 filter match gated by its enable
                ev_wf = good & q.wfe & wf_hit;
                // R9 unicast wake in power save
                ev_uc = good & q.global_unicast_wake_enable & n.unicast & power_save;
            end
        end

        // R11 magic packet status
        n.magic_packet_received = n.magic_packet_received | ev_magic;
        // R10 wake frame status
        n.wfr = n.wfr | ev_wf;
        n.irq_st[IRQ_MAGIC] = n.irq_st[IRQ_MAGIC] | ev_magic;
        n.irq_st[IRQ_WFRAME] = n.irq_st[IRQ_WFRAME] | ev_wf;
        n.irq_st[IRQ_UNICAST] = n.irq_st[IRQ_UNICAST] | ev_uc;
        n.irq_st[IRQ_OVERSIZE] = n.irq_st[IRQ_OVERSIZE] |
                                 (n.frame_done & n.long);
        n.irq = |(n.irq_st & n.irq_en);
        n.wake_req = power_save & (ev_magic | ev_wf | ev_uc);
    end

    // ********************************************************
    // registers
    // ********************************************************
    // R5 reset clears the filter index
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign hreadyout = ~q.rd_wait;
    assign hrdata = q.hrdata;
    assign hresp = HRESP_OKAY;
    assign wake_req = q.wake_req;
    assign frame_done = q.frame_done;
    assign vlan_one_hit = q.v1;
    assign vlan_two_hit = q.v2;
    assign frame_too_long = q.long;
    assign irq = q.irq;

    // ********************************************************
    // assertions
    // ********************************************************
    a_vlan_one_cmp: assert property ( // R1
        @(posedge ref_clk) disable iff (!rst_n)
        q.frame_done |-> q.v1 == ({q.type_hi, q.type_lo} ==
                                  $past(q.vlan_one)))
        else $error("first vlan compare wrong");

    a_vlan_two_cmp: assert property ( // R2
        @(posedge ref_clk) disable iff (!rst_n)
        q.frame_done |-> q.v2 == ({q.type_hi, q.type_lo} ==
                                  $past(q.vlan_two)))
        else $error("second vlan compare wrong");

    a_len_limit: assert property ( // R3
        @(posedge ref_clk) disable iff (!rst_n)
        q.frame_done |-> q.long == (q.last_len > ((q.v1 || q.v2) ?
                                    LEN_MAX_VLAN : LEN_MAX_PLAIN)))
        else $error("frame length limit wrong");

    a_index_reset: assert property ( // R5
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(rst_n) |-> q.wf_idx == 3'h0)
        else $error("filter index not zero after reset");

    a_index_step: assert property ( // R6
        @(posedge ref_clk) disable iff (!rst_n)
        fw_wr && q.wf_idx != 3'h7 |=> q.wf_idx == $past(q.wf_idx) + 3'h1)
        else $error("filter index did not advance");

    a_index_wrap: assert property ( // R7
        @(posedge ref_clk) disable iff (!rst_n)
        fw_wr && q.wf_idx == 3'h7 |=> q.wf_idx == 3'h0)
        else $error("filter index did not wrap");

    a_filter_read: assert property ( // R8
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(q.rd_wait) && q.ph_idx == IDX_WAKE_FILTER |->
        hrdata == 32'h0000_0000 && hreadyout)
        else $error("filter port read not zero");

    a_unicast_wake: assert property ( // R9
        @(posedge ref_clk) disable iff (!rst_n)
        rx_valid && rx_eof && !rx_sof && !rx_err && power_save && q.global_unicast_wake_enable &&
        q.unicast |=> wake_req && q.irq_st[IRQ_UNICAST])
        else $error("unicast wake missed");

    a_wframe_flag: assert property ( // R10
        @(posedge ref_clk) disable iff (!rst_n)
        rx_valid && rx_eof && !rx_err && q.wfe && wf_hit |=>
        q.wfr && q.irq_st[IRQ_WFRAME])
        else $error("wake frame flag not set");

    a_magic_flag: assert property ( // R11
        @(posedge ref_clk) disable iff (!rst_n)
        rx_valid && rx_eof && !rx_err && q.mpe && magic_found |=>
        q.magic_packet_received ##1 q.magic_packet_received || $past(bus_wr))
        else $error("magic packet flag not set");

    a_wframe_gate: assert property ( // R12
        @(posedge ref_clk) disable iff (!rst_n)
        !q.wfe && !q.wfr && !bus_wr |=> !q.wfr)
        else $error("wake frame flag set while disabled");

    a_magic_gate: assert property ( // R13
        @(posedge ref_clk) disable iff (!rst_n)
        rx_valid && rx_eof && !q.mpe && !q.wfe && !q.global_unicast_wake_enable |=> !wake_req)
        else $error("wake raised with all wake sources off");

endmodule : mac_vlan_wake

`default_nettype wire

// ===== src/magic_detect.sv
// Purpose: spots a magic packet anywhere in the received bytes
// Assumes: frame_start comes with the first byte of each frame
// Notes:   found stays high until the next frame starts
`timescale 1ns/10ps
`default_nettype none

module magic_detect (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic frame_start,
    input wire logic [7:0] byte_data,
    input wire logic [47:0] station_addr,
    output logic found
);
    import mac_wake_pkg::*;

    typedef struct packed {
        logic [2:0] ff_cnt;
        logic in_addr;
        logic [3:0] rep;
        logic [2:0] bi;
        logic found;
    } mg_st_t;

    mg_st_t q;
    mg_st_t n;
    mg_st_t s;

    // first byte on the wire is the most significant address byte
    function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                             input logic [2:0] i);
        return a[8*(5-i) +: 8];
    endfunction : addr_byte

    // ********************************************************
    // R14 sync run then sixteen address copies
    // ********************************************************
    always_comb begin
        s = q;
        if (frame_start) begin
            s = '0;
        end
        n = s;
        if (byte_valid) begin
            if (!s.in_addr) begin
                if (byte_data != MAGIC_SYNC_BYTE) begin
                    n.ff_cnt = 3'h0;
                end else if (s.ff_cnt == MAGIC_SYNC_LEN - 3'h1) begin
                    n.in_addr = 1'b1;
                    n.rep = 4'h0;
                    n.bi = 3'h0;
                end else begin
                    n.ff_cnt = s.ff_cnt + 3'h1;
                end
            end else if (byte_data == addr_byte(station_addr, s.bi)) begin
                if (s.bi != MAGIC_LAST_BYTE) begin
                    n.bi = s.bi + 3'h1;
                end else if (s.rep != MAGIC_LAST_REP) begin
                    n.bi = 3'h0;
                    n.rep = s.rep + 4'h1;
                end else begin
                    n.found = 1'b1;
                    n.in_addr = 1'b0;
                    n.ff_cnt = 3'h0;
                end
            end else if (byte_data == MAGIC_SYNC_BYTE && s.bi == 3'h0 &&
                         s.rep == 4'h0) begin
                // a longer sync run keeps us aligned
                n.in_addr = 1'b1;
            end else begin
                n.in_addr = 1'b0;
                n.ff_cnt = (byte_data == MAGIC_SYNC_BYTE) ? 3'h1 : 3'h0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign found = q.found;

endmodule : magic_detect

`default_nettype wire

// ===== src/wake_filter_mem.sv
// Purpose: eight-word store behind the write-only wake filter port
// Assumes: one write port; every word is visible at once for matching
// Notes:   contents come straight out of flip-flops
`timescale 1ns/10ps
`default_nettype none

module wake_filter_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [DEPTH*WIDTH-1:0] words
);
    import mac_wake_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] w;
    } fm_st_t;

    fm_st_t q;
    fm_st_t n;

    always_comb begin
        n = q;
        if (wr_en) begin
            n.w[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign words = q.w;

endmodule : wake_filter_mem

`default_nettype wire

// ===== testbench/rx_source.sv
// Purpose: receive-path byte source standing in for the phy side
// Assumes: the bench fills q with one whole frame before each send
// Notes:   idle data is inverted so stale bytes never look valid
`timescale 1ns/10ps
`default_nettype none

module rx_source (
    input wire logic ref_clk,
    output logic rx_valid,
    output logic rx_sof,
    output logic rx_eof,
    output logic rx_err,
    output logic [7:0] rx_data
);
    logic [7:0] q[$];

    initial begin
        rx_valid = 1'b0;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
        rx_err = 1'b0;
        rx_data = 8'hA5;
    end

    // slow mode leaves an idle cycle after the second byte and every third one after it
    task automatic send(input logic err, input logic slow);
        for (int i = 0; i < q.size(); i++) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_sof <= (i == 0);
            rx_eof <= (i == q.size() - 1);
            rx_err <= err;
            rx_data <= q[i];
            if (slow && i % 3 == 1 && i < q.size() - 1) begin
                @(posedge ref_clk);
                rx_valid <= 1'b0;
                rx_data <= ~q[i];
            end
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_eof <= 1'b0;
        rx_data <= ~q[q.size() - 1];
    endtask : send
endmodule : rx_source

`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the vlan tag and wake detect block
// Assumes: one ahb master, one frame in flight at a time
// Notes:   expectations come from an integer model kept in the bench
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import mac_wake_pkg::*;
    logic ref_clk, rst_n, hsel, hwrite, hreadyout, power_save;
    logic rx_valid, rx_sof, rx_eof, rx_err, wake_req, frame_done;
    logic hit1, hit2, too_long, irq;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize;
    logic [7:0] rx_data;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [47:0] station_addr;
    logic [7:0] fr[$];
    int miscompares, tests_run, seed, tag1, tag2, ctrl, st, irqst, fen;
    int lens[6] = '{1522, 1523, 1518, 1519, 1522, 1523};
    logic [15:0] typs[6] = '{16'h8100, 16'h8100, 16'h0800, 16'h0800,
        16'h88A8, 16'h88A8};

    rx_source i_src (.ref_clk(ref_clk), .rx_valid(rx_valid),
        .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_err(rx_err),
        .rx_data(rx_data));
    mac_vlan_wake i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rx_valid(rx_valid),
        .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_err(rx_err),
        .rx_data(rx_data), .station_addr(station_addr),
        .power_save(power_save), .wake_req(wake_req),
        .frame_done(frame_done), .vlan_one_hit(hit1),
        .vlan_two_hit(hit2), .frame_too_long(too_long), .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ********************************************************
    // tasks
    // ********************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk

    function automatic logic [31:0] ad(input logic [5:0] i);
        return {24'h0, i, 2'h0};
    endfunction : ad

    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", HRESP_OKAY, hresp);
    endtask : bus

    // zero byte masks give a crc of the init value for an enabled filter
    task automatic filt(input int en);
        for (int w = 0; w < 8; w++) begin
            bus(1'b1, ad(IDX_WAKE_FILTER),
                w == 4 ? en : (w == 6 ? 32'h0000FFFF : 0));
        end
        fen = en;
        bus(1'b0, ad(IDX_WAKE_FILTER), 0);
        chk("filter read", 0, rd);
    endtask : filt

    task automatic frame(input int len, input logic [15:0] typ,
            input logic uni, mag, err);
        int t, lng, mg, wf, un;
        fr.delete();
        for (int i = 0; i < len; i++) fr.push_back(8'($random(seed)));
        fr[0][0] = ~uni;
        fr[12] = typ[15:8];
        fr[13] = typ[7:0];
        for (int i = 0; mag && i < 102; i++) begin
            fr[14 + i] = i < 6 ? 8'hFF :
                station_addr[47 - 8 * ((i - 6) % 6) -: 8];
        end
        t = {fr[12], fr[13]};
        lng = len > ((t == tag1 || t == tag2) ? 1522 : 1518);
        mg = mag && ctrl[1] && !err;
        wf = fen && ctrl[2] && !err;
        un = ctrl[9] && uni && !err && power_save;
        st |= (mg << 5) | (wf << 6);
        irqst |= mg | (wf << 1) | (un << 2) | (lng << 3);
        i_src.q = fr;
        i_src.send(err, 1'(len % 2));
        for (int k = 0; k < 8; k++) begin
            @(negedge ref_clk);
            if (frame_done === 1'b1) break;
        end
        chk("frame_done", 1, frame_done);
        chk("vlan one", t == tag1, hit1);
        chk("vlan two", t == tag2, hit2);
        chk("too long", lng, too_long);
        chk("wake", power_save && (mg || wf || un), wake_req);
        $display("frame of %0d bytes checked", len);
    endtask : frame

    // ********************************************************
    // sequence
    // ********************************************************
    initial begin
        seed = 92975;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = HSIZE_WORD;
        rst_n = 1'b0;
        power_save = 1'b1;
        station_addr = {16'h02A1, 32'($random(seed))};
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 8; i <= 17; i++) begin
            bus(1'b0, ad(6'(i)), 0);
            chk("reset value", REG_RST, rd);
        end
        $display("reset values checked");
        tag1 = $random(seed);
        bus(1'b1, ad(IDX_VLAN_ONE), tag1);
        bus(1'b0, ad(IDX_VLAN_ONE), 0);
        chk("tag one", tag1 & 32'hFFFF, rd);
        tag1 = 32'h8100;
        tag2 = 32'h88A8;
        bus(1'b1, ad(IDX_VLAN_ONE), tag1);
        bus(1'b1, ad(IDX_VLAN_TWO), tag2);
        bus(1'b0, ad(IDX_VLAN_TWO), 0);
        chk("tag two", tag2, rd);
        foreach (lens[i]) frame(lens[i], typs[i], 1'b0, 1'b0, 1'b0);
        // mid-run reset must pull the filter index back to word 0
        bus(1'b1, ad(IDX_WAKE_FILTER), 32'h1);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        irqst = 0;
        filt(1);
        ctrl = 32'h206;
        bus(1'b1, ad(IDX_WAKE_CTRL), ctrl);
        bus(1'b1, ad(IDX_IRQ_ENABLE), 32'h7);
        frame(80, 16'h0800, 1'b1, 1'b0, 1'b0);
        frame(120, 16'h0800, 1'b0, 1'b1, 1'b0);
        frame(120, 16'h0800, 1'b1, 1'b1, 1'b1);
        bus(1'b0, ad(IDX_WAKE_CTRL), 0);
        chk("wake status", ctrl | st, rd);
        bus(1'b0, ad(IDX_IRQ_STATUS), 0);
        chk("irq status", irqst, rd);
        chk("irq high", 1, irq);
        bus(1'b1, ad(IDX_IRQ_CLEAR), 32'hF);
        bus(1'b1, ad(IDX_WAKE_CTRL), ctrl | 32'h60);
        repeat (3) @(negedge ref_clk);
        chk("irq low", 0, irq);
        {irqst, st} = '0;
        filt(0);
        ctrl = 32'h204;
        bus(1'b1, ad(IDX_WAKE_CTRL), ctrl);
        power_save <= 1'b0;
        frame(120, 16'h0800, 1'b1, 1'b1, 1'b0);
        bus(1'b0, ad(IDX_WAKE_CTRL), 0);
        chk("wake status", ctrl | st, rd);
        conclude();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end
endmodule : tb_top

`default_nettype wire
